/* adc_input_channel_mux.sv */
// Contract
// - Single-ended: one positive input at most.
// - Six-bit code field, resets all ones.
// - Codes 0-31 select port pins linearly.
// - Temp sensor, supply, then ground codes.
//
// The plain strobed port was chosen for this implementation.
`timescale 1ns/1ps
module adc_input_channel_mux (
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire logic ce_in,
  input wire logic [7:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [7:0] rdata_out,
  output logic [adc_mux_pkg::SEL_W-1:0] switch_sel_out,
  output logic [5:0] positive_input_code_out
);
  logic [5:0] code_r;
  logic [5:0] code_lag1_r;
  logic [5:0] code_lag2_r;
  logic [adc_mux_pkg::SEL_W-1:0] sel_w;
  logic hit;

  assign hit = (addr_in == adc_mux_pkg::CHAN_SEL_OFFSET);

  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      code_r <= adc_mux_pkg::CHAN_SEL_RESET[5:0];
    end else if (ce_in && wr_in && hit) begin
      code_r <= wdata_in[5:0];
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      rdata_out <= 8'h00;
    end else if (ce_in) begin
      rdata_out <= (rd_in && hit) ? {2'b00, code_r} : 8'h00;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      positive_input_code_out <= adc_mux_pkg::CHAN_SEL_RESET[5:0];
    end else if (ce_in) begin
      positive_input_code_out <= code_r;
    end
  end

  adc_onehot_decoder #(
    .SEL_W(adc_mux_pkg::SEL_W)
  ) u_dec (
    .clk_sys_in(clk_sys_in),
    .rst_n_in(rst_n_in),
    .ce_in(ce_in),
    .code_in(code_r),
    .sel_out(sel_w)
  );

  // Copy keeps the top output straight from a flip-flop of this module.
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      switch_sel_out <= '0;
      switch_sel_out[adc_mux_pkg::SEL_GND] <= 1'b1;
    end else if (ce_in) begin
      switch_sel_out <= sel_w;
    end
  end

  // Shadow of decode pipeline.
  // The shadow lets each switch be checked against the code it must show,
  // rather than against a copy of the decoder's own output.
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      code_lag1_r <= adc_mux_pkg::CHAN_SEL_RESET[5:0];
    end else if (ce_in) begin
      code_lag1_r <= code_r;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      code_lag2_r <= adc_mux_pkg::CHAN_SEL_RESET[5:0];
    end else if (ce_in) begin
      code_lag2_r <= code_lag1_r;
    end
  end

  AST_ONE_HOT: assert property (
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    $onehot0(switch_sel_out))
    else $error("More than one analog switch enabled.");

  AST_WRITE: assert property (
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    ce_in && wr_in && hit |=> code_r == $past(wdata_in[5:0]))
    else $error("Code field did not take written value.");

  AST_READ: assert property (
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    ce_in && rd_in && hit && !wr_in |=>
    rdata_out == {2'b00, $past(code_r)})
    else $error("Read data wrong.");

  AST_PIN: assert property (
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    ce_in && code_r <= 6'h1f ##1 ce_in ##1 ce_in |->
    switch_sel_out[$past(code_r, 2)])
    else $error("Pin code did not select its pin.");

  AST_TEMP: assert property (
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    ce_in && code_r == 6'h30 ##1 ce_in ##1 ce_in |->
    switch_sel_out[32])
    else $error("Temperature code not routed.");

  AST_VDD: assert property (
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    ce_in && code_r == 6'h31 ##1 ce_in ##1 ce_in |->
    switch_sel_out[33])
    else $error("Supply code not routed.");

  AST_GND: assert property (
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    ce_in && code_r >= 6'h32 ##1 ce_in ##1 ce_in |->
    switch_sel_out[34])
    else $error("Ground code not routed.");

  AST_RSVD: assert property (
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    ce_in && code_r inside {[6'h20:6'h2f]} ##1 ce_in ##1 ce_in |->
    switch_sel_out == '0)
    else $error("Reserved code closed a switch.");

  AST_STABLE: assert property (
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    !ce_in |=> $stable(switch_sel_out))
    else $error("Switch select moved while frozen.");

  AST_RST_VAL: assert property (
    @(posedge clk_sys_in)
    !rst_n_in |=> code_r == adc_mux_pkg::CHAN_SEL_RESET[5:0])
    else $error("Reset did not load the code field.");

  AST_RST_SEL: assert property (
    @(posedge clk_sys_in)
    !rst_n_in |=> switch_sel_out[adc_mux_pkg::SEL_GND] &&
    $onehot(switch_sel_out))
    else $error("Reset did not route ground.");

  AST_WR_IGNORE: assert property (
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    ce_in && wr_in && !hit |=> $stable(code_r))
    else $error("Write to another address changed the code.");

  AST_FROZEN: assert property (
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    !ce_in |=> $stable(code_r) && $stable(rdata_out) &&
    $stable(positive_input_code_out))
    else $error("State moved while frozen.");

  AST_RD_IDLE: assert property (
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    ce_in && !(rd_in && hit) |=> rdata_out == 8'h00)
    else $error("Read data not zero outside a read.");

  AST_TOP_ZERO: assert property (
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    rdata_out[7:6] == 2'b00)
    else $error("Unused read bits not zero.");

  AST_CODE_OUT: assert property (
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    ce_in |=> positive_input_code_out == $past(code_r))
    else $error("Code output did not follow the field.");

  AST_EXACT_ONE: assert property (
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    !(code_lag2_r inside {[6'h20:6'h2f]}) |-> $onehot(switch_sel_out))
    else $error("Valid code did not close exactly one switch.");

  AST_RSVD_MAP: assert property (
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    code_lag2_r inside {[6'h20:6'h2f]} |-> switch_sel_out == '0)
    else $error("Reserved code left a switch closed.");

  AST_DEC_ONEHOT: assert property (
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    $onehot0(sel_w))
    else $error("Decoder stage selects more than one switch.");

  AST_SEL_FOLLOW: assert property (
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    ce_in |=> switch_sel_out == $past(sel_w))
    else $error("Switch select did not follow decoder.");

  for (genvar g = 0; g < adc_mux_pkg::PIN_COUNT; g++) begin : g_pin_chk
    AST_PIN_MAP: assert property (
      @(posedge clk_sys_in) disable iff (!rst_n_in)
      switch_sel_out[g] == (code_lag2_r == 6'(g)))
      else $error("Pin switch does not match its code.");
  end
endmodule // adc_input_channel_mux

/* adc_mux_pkg.sv */
package adc_mux_pkg;
  localparam logic [7:0] CHAN_SEL_OFFSET = 8'hbb;
  localparam logic [7:0] CHAN_SEL_RESET = 8'h3f;
  localparam int CODE_W = 6;
  localparam int CODE_MSB = 5;
  localparam int CODE_LSB = 0;
  localparam int PIN_COUNT = 32;
  localparam int PINS_PER_PORT = 8;
  localparam logic [5:0] LAST_PIN_CODE = 6'h1f;
  localparam logic [5:0] TEMP_CODE = 6'h30;
  localparam logic [5:0] VDD_CODE = 6'h31;
  localparam logic [5:0] GND_FIRST_CODE = 6'h32;
  localparam int SEL_W = 35;
  localparam int SEL_TEMP = 32;
  localparam int SEL_VDD = 33;
  localparam int SEL_GND = 34;
endpackage

/* adc_onehot_decoder.sv */
`timescale 1ns/1ps
module adc_onehot_decoder #(
  parameter int SEL_W = adc_mux_pkg::SEL_W
) (
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire logic ce_in,
  input wire logic [5:0] code_in,
  output logic [SEL_W-1:0] sel_out
);
  logic [SEL_W-1:0] sel_nxt;

  // Reserved codes leave every switch open.
  always_comb begin
    sel_nxt = '0;
    if (code_in <= adc_mux_pkg::LAST_PIN_CODE) begin
      sel_nxt[code_in[4:0]] = 1'b1;
    end else if (code_in == adc_mux_pkg::TEMP_CODE) begin
      sel_nxt[adc_mux_pkg::SEL_TEMP] = 1'b1;
    end else if (code_in == adc_mux_pkg::VDD_CODE) begin
      sel_nxt[adc_mux_pkg::SEL_VDD] = 1'b1;
    end else if (code_in >= adc_mux_pkg::GND_FIRST_CODE) begin
      sel_nxt[adc_mux_pkg::SEL_GND] = 1'b1;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      sel_out <= '0;
      sel_out[adc_mux_pkg::SEL_GND] <= 1'b1;
    end else if (ce_in) begin
      sel_out <= sel_nxt;
    end
  end
endmodule // adc_onehot_decoder

/* analog_source_model.sv */
`timescale 1ns/1ps
module analog_source_model (
  input wire logic [adc_mux_pkg::SEL_W-1:0] sel_in,
  input wire logic [31:0] pin_input_mode_bits_in,
  input wire logic [31:0] pin_crossbar_skip_bits_in,
  output logic [5:0] count_out,
  output logic [5:0] src_out,
  output logic ready_out
);
  // Mode zero, skip one.
  // A pin left digital would load the converter input.
  always_comb begin
    ready_out = 1'b1;
    for (int i = 0; i < adc_mux_pkg::PIN_COUNT; i++) begin
      if (sel_in[i] === 1'b1) begin
        ready_out = !pin_input_mode_bits_in[i] &&
          pin_crossbar_skip_bits_in[i];
      end
    end
  end
  // single source.
  // Counting every closed switch exposes any overlap.
  always_comb begin
    count_out = 6'h00;
    src_out = 6'h3f;
    for (int i = 0; i < adc_mux_pkg::SEL_W; i++) begin
      if (sel_in[i] === 1'b1) begin
        count_out = count_out + 6'h01;
        src_out = 6'(i);
      end
    end
  end
endmodule // analog_source_model

/* adc_input_channel_mux_bench.sv */
`timescale 1ns/1ps
module adc_input_channel_mux_bench;
  logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, ce = 1'b1, rdy;
  logic [31:0] mode_bits = 32'h0000_0000, skip_bits = 32'hffff_ffff;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, d;
  logic [adc_mux_pkg::SEL_W-1:0] sel;
  logic [5:0] code, cnt, src, c;
  logic [7:0] codes [8] = '{8'h00, 8'h1f, 8'h20, 8'h2f, 8'h30, 8'h31,
    8'h32, 8'hff};
  int fails = 0, comparisons = 0;
  always #5 clk = ~clk;
  adc_input_channel_mux uut (.clk_sys_in(clk), .rst_n_in(rst_n),
    .ce_in(ce), .addr_in(addr), .wdata_in(wdata), .wr_in(wr),
    .rd_in(rd), .rdata_out(rdata), .switch_sel_out(sel),
    .positive_input_code_out(code));
  analog_source_model far (.sel_in(sel),
    .pin_input_mode_bits_in(mode_bits),
    .pin_crossbar_skip_bits_in(skip_bits),
    .count_out(cnt), .src_out(src), .ready_out(rdy));
  task chk_byte(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t byte %h exp %h", $time, got, exp);
    end
  endtask
  task chk_src(input logic [5:0] es, input logic [5:0] ec);
    comparisons++;
    if ({src, cnt} !== {es, ec}) begin
      fails++;
      $display("MISMATCH t=%0t src %h n %h", $time, src, cnt);
    end
  endtask
  task wr_reg(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task rd_reg(input logic [7:0] a);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  task test_done;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    rd_reg(8'hbb);
    chk_byte(d, 8'h3f);
    chk_src(6'd34, 6'h01);
    foreach (codes[i]) begin
      c = codes[i][5:0];
      wr_reg(8'hbb, codes[i]);
      repeat (4) @(posedge clk);
      rd_reg(8'hbb);
      chk_byte(d, {2'b00, c});
      chk_byte({2'b00, code}, {2'b00, c});
      chk_byte({7'h00, rdy}, 8'h01);
      if (c < 6'h20) chk_src(c, 6'h01);
      else if (c < 6'h30) chk_src(6'h3f, 6'h00);
      else chk_src(c > 6'h31 ? 6'd34 : c - 6'h10, 6'h01);
    end
    $display("test codes done");
    @(posedge clk);
    ce <= 1'b0;
    wr_reg(8'hbb, 8'h05);
    repeat (3) @(posedge clk);
    ce <= 1'b1;
    rd_reg(8'hbb);
    chk_byte(d, 8'h3f);
    chk_src(6'd34, 6'h01);
    $display("test freeze done");
    wr_reg(8'hba, 8'h05);
    rd_reg(8'hba);
    chk_byte(d, 8'h00);
    rd_reg(8'hbb);
    chk_byte(d, 8'h3f);
    chk_src(6'd34, 6'h01);
    $display("test unmapped done");
    test_done();
  end
endmodule // adc_input_channel_mux_bench
